// *** tb/mac_tx_model.sv ***
// MAC transmit model: sends a frame of len nibbles after a start pulse
module mac_tx_model (
  input logic clk,
  input logic start,
  input logic [3:0] len,
  output logic txEn,
  output logic txEr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left = 4'h0;
  // Enable held while nibbles remain; this MAC never signals an error
  always @(posedge clk) begin
    if (start)
      left <= len;
    else if (left != 4'h0)
      left <= left - 4'h1;
  end
  assign txEn = left != 4'h0;
  assign txEr = 1'b0;
endmodule

// *** tb/phy_link_option_checker.sv ***
// Assertion checker for the link option controls
module phy_link_option_checker (
  input logic clk,
  input logic rst_n,
  input logic [4:0] regAddr,
  input logic [15:0] regWdata,
  input logic regWrite,
  input logic regRead,
  input logic [15:0] regRdata,
  input logic autoNegEnable,
  input logic forced100Tx,
  input logic partnerForced100Tx,
  input logic linkUp,
  input logic linkSpeed100,
  input logic linkLed,
  input logic miiIsolate_n,
  input logic resolvedFullDuplex,
  input logic rxIdle,
  input logic rxSymbolError,
  input logic rxErOut,
  input logic txEnIn,
  input logic txEnOut,
  input logic eqErrorRaw,
  input logic eqError,
  input logic eqCoef0Bypass,
  input logic [3:0] fastDropTriggers,
  input logic descramblerLockLoss,
  input logic fastLinkDown
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] c2;
  logic [15:0] c3;
  logic odd;
  wire drop = |(fastDropTriggers & c3[3:0]) | (descramblerLockLoss & c3[10]);
  wire eqExp = eqErrorRaw & ~c3[12];
  wire coef = c3[9];
  wire idleDet = c2[2];
  wire isoOn = c2[3];
  wire oddChk = odd & ~c2[1];
  wire [15:0] rdExp = regAddr == 5'h0a ? c2 :
    regAddr == 5'h0b ? c3 : 16'h0000;
  // Shadow fields from the write strobe; parity counts enabled nibbles
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c2 <= 16'h0000;
      c3 <= 16'h1000;
      odd <= 1'b0;
    end else begin
      if (regWrite && regAddr == 5'h0a) c2 <= regWdata & 16'h003f;
      if (regWrite && regAddr == 5'h0b) c3 <= regWdata & 16'h160f;
      odd <= txEnIn ? ~odd : 1'b0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rd; regRead |=> regRdata == $past(rdExp); endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
  property p_idle; !regRead |=> regRdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("stray read data");
  property p_drop; 1 |=> fastLinkDown == $past(drop); endproperty
  a_drop: assert property (p_drop) else $error("fast drop wrong");
  property p_eq;
    1 |=> eqError == $past(eqExp) && eqCoef0Bypass == $past(coef);
  endproperty
  a_eq: assert property (p_eq) else $error("equalizer wrong");
  property p_rxer;
    rxIdle && (rxSymbolError || !idleDet) |=> rxErOut == $past(idleDet);
  endproperty
  a_rxer: assert property (p_rxer) else $error("idle error wrong");
  property p_iso;
    linkUp && !linkSpeed100 |=> miiIsolate_n == !$past(isoOn);
  endproperty
  a_iso: assert property (p_iso) else $error("isolate wrong");
  property p_txen; txEnIn |=> txEnOut; endproperty
  a_txen: assert property (p_txen) else $error("enable lost");
  property p_odd; $fell(txEnIn) |=> txEnOut == $past(oddChk); endproperty
  a_odd: assert property (p_odd) else $error("odd end wrong");
  property p_dup;
    c2[5] && partnerForced100Tx && (autoNegEnable || forced100Tx)
      |=> resolvedFullDuplex;
  endproperty
  a_dup: assert property (p_dup) else $error("not full duplex");
  property p_led; !linkUp || (c2[4] && !linkSpeed100) |=> !linkLed;
  endproperty
  a_led: assert property (p_led) else $error("led lit");
endmodule

bind phy_link_option_controls phy_link_option_checker checkInst (.*);

// *** tb/tb_top.sv ***
// Self-checking bench for the link option controls
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, regWrite = 0, regRead = 0, go = 0;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWdata = 16'h0000, regRdata;
  logic [3:0] len = 4'h0, fastDropTriggers = 4'h0;
  logic [1:0] rxdPin = 2'b00, rmiiRxd;
  logic autoNegEnable = 0, localFdAbility = 0, partnerAutoNeg = 0;
  logic partnerFdAbility = 0, partnerForced100Tx = 0, linkUp = 0;
  logic linkSpeed100 = 0, linkActivity = 0, rxIdle = 0, rxSymbolError = 0;
  logic rxClkPin = 0, crystal_reference_input = 0, eqErrorRaw = 0;
  logic descramblerLockLoss = 0, forced100Tx = 0, forcedFullDuplex = 0;
  logic linkFiber = 0;
  logic resolvedFullDuplex, linkLed, miiIsolate_n, rxErOut, txEnOut;
  logic txErOut, eqError, eqCoef0Bypass, fastLinkDown, rmiiRxdStrobe;
  wire txEnIn, txErIn;
  integer n_fail = 0, tests_run = 0;
  // Short blink period keeps the activity phase visible in a few cycles
  phy_link_option_controls #(.BLINK_CYCLES(4)) uut (.*);
  mac_tx_model mac (.clk(clk), .start(go), .len(len), .txEn(txEnIn),
    .txEr(txErIn));
  initial begin
    forever #5 clk = ~clk;
  end
  task end_of_test;
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1;
    @(posedge clk);
    regWrite <= 0;
  endtask
  task rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1;
    @(posedge clk);
    regRead <= 0;
    #1;
    chk(regRdata, e);
  endtask
  task drop(input logic [3:0] t, input logic l, input logic e);
    @(posedge clk);
    fastDropTriggers <= t;
    descramblerLockLoss <= l;
    settle;
    chk(fastLinkDown, e);
  endtask
  task count_led(output integer on);
    settle;
    on = 0;
    repeat (16) begin
      @(posedge clk);
      #1;
      if (linkLed === 1'b1)
        on++;
    end
  endtask
  task t_tx(input logic [3:0] n, input logic dis);
    integer en, er;
    en = 0;
    er = 0;
    wr(5'h0a, {14'h0000, dis, 1'b0});
    go <= 1;
    len <= n;
    @(posedge clk);
    go <= 0;
    repeat (12) begin
      @(posedge clk);
      #1;
      en += txEnOut === 1'b1;
      er += txErOut === 1'b1;
    end
    chk(en[15:0], n + (n[0] & ~dis));
    chk(er[15:0], n[0] & ~dis);
  endtask
  task t_rmii(input logic sel, input logic pin);
    integer i, s;
    s = 0;
    wr(5'h0a, {15'h0000, sel});
    rxdPin <= 2'b10;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (pin)
        rxClkPin <= i[2];
      else
        crystal_reference_input <= i[2];
      #1;
      s += rmiiRxdStrobe === 1'b1;
    end
    chk(s != 0, sel == pin);
    if (sel == pin)
      chk(rmiiRxd, 2'b10);
  endtask
  task t_regs;
    rd(5'h0a, 16'h0000);
    rd(5'h0b, 16'h1000);
    wr(5'h0a, 16'hffff);
    rd(5'h0a, 16'h003f);
    wr(5'h0b, 16'hffff);
    rd(5'h0b, 16'h160f);
    wr(5'h0c, 16'hffff);
    rd(5'h0c, 16'h0000);
  endtask
  task t_drop;
    integer i;
    logic [15:0] m;
    for (i = 0; i < 5; i++) begin
      m = i < 4 ? 16'h0001 << i : 16'h0400;
      wr(5'h0b, m);
      drop(m[3:0], i == 4, 1'b1);
      drop(~m[3:0], i != 4, 1'b0);
    end
  endtask
  task t_eq;
    wr(5'h0b, 16'h1000);
    eqErrorRaw <= 1;
    settle;
    chk({eqError, eqCoef0Bypass}, 16'h0000);
    wr(5'h0b, 16'h0200);
    settle;
    chk({eqError, eqCoef0Bypass}, 16'h0003);
  endtask
  task t_duplex;
    wr(5'h0a, 16'h0000);
    partnerForced100Tx <= 1;
    autoNegEnable <= 1;
    localFdAbility <= 1;
    settle;
    chk(resolvedFullDuplex, 1'b0);
    wr(5'h0a, 16'h0020);
    settle;
    chk(resolvedFullDuplex, 1'b1);
    @(posedge clk);
    autoNegEnable <= 0;
    forced100Tx <= 1;
    settle;
    chk(resolvedFullDuplex, 1'b1);
    wr(5'h0a, 16'h0000);
    settle;
    chk(resolvedFullDuplex, 1'b0);
    @(posedge clk);
    forcedFullDuplex <= 1;
    settle;
    chk(resolvedFullDuplex, 1'b1);
    @(posedge clk);
    autoNegEnable <= 1;
    forced100Tx <= 0;
    forcedFullDuplex <= 0;
  endtask
  task t_led_iso;
    integer on;
    wr(5'h0a, 16'h0000);
    partnerForced100Tx <= 0;
    partnerAutoNeg <= 1;
    partnerFdAbility <= 1;
    linkUp <= 1;
    linkSpeed100 <= 1;
    count_led(on);
    chk(on[15:0], 16'h0010);
    @(posedge clk);
    linkActivity <= 1;
    count_led(on);
    chk(on < 16, 1'b1);
    wr(5'h0a, 16'h0010);
    count_led(on);
    chk(on[15:0], 16'h0010);
    @(posedge clk);
    linkFiber <= 1;
    count_led(on);
    chk(on[15:0], 16'h0000);
    @(posedge clk);
    linkFiber <= 0;
    linkSpeed100 <= 0;
    count_led(on);
    chk(on[15:0], 16'h0000);
    wr(5'h0a, 16'h0008);
    settle;
    chk(miiIsolate_n, 1'b0);
    @(posedge clk);
    linkSpeed100 <= 1;
    settle;
    chk(miiIsolate_n, 1'b1);
    @(posedge clk);
    partnerFdAbility <= 0;
    count_led(on);
    chk(miiIsolate_n, 1'b0);
  endtask
  task t_rxer;
    wr(5'h0a, 16'h0004);
    rxIdle <= 1;
    rxSymbolError <= 1;
    settle;
    chk(rxErOut, 1'b1);
    wr(5'h0a, 16'h0000);
    settle;
    chk(rxErOut, 1'b0);
    @(posedge clk);
    rxIdle <= 0;
    settle;
    chk(rxErOut, 1'b1);
  endtask
  task t_reset;
    wr(5'h0a, 16'h002a);
    wr(5'h0b, 16'h0000);
    settle;
    chk(eqError, 1'b1);
    @(posedge clk);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rd(5'h0a, 16'h0000);
    rd(5'h0b, 16'h1000);
    chk({eqError, miiIsolate_n}, 16'h0001);
  endtask
  initial begin
    integer i;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    t_regs;
    t_drop;
    t_eq;
    t_duplex;
    t_led_iso;
    t_rxer;
    for (i = 0; i < 4; i++) begin
      t_tx(4'h3 + i[0], i[1]);
      t_rmii(i[1], i[0]);
    end
    t_reset;
    end_of_test;
  end
  // Cuts a hang short well beyond the expected run length
  initial begin
    #100000;
    n_fail++;
    end_of_test;
  end
endmodule

// *** verilog/phy_link_option_controls.v ***
// Link and MAC-interface option controls of a 10/100 transceiver
`include "phy_link_option_defines.vh"

module phy_link_option_controls #(
  parameter BLINK_CYCLES = `LED_BLINK_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire [4:0] regAddr,
  input wire [15:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [15:0] regRdata,
  input wire autoNegEnable,
  input wire forced100Tx,
  input wire forcedFullDuplex,
  input wire localFdAbility,
  input wire partnerAutoNeg,
  input wire partnerFdAbility,
  input wire partnerForced100Tx,
  input wire linkUp,
  input wire linkSpeed100,
  input wire linkFiber,
  input wire linkActivity,
  output reg resolvedFullDuplex,
  output reg linkLed,
  output reg miiIsolate_n,
  input wire rxIdle,
  input wire rxSymbolError,
  output reg rxErOut,
  input wire txEnIn,
  input wire txErIn,
  output reg txEnOut,
  output reg txErOut,
  input wire rxClkPin,
  input wire crystal_reference_input,
  input wire [1:0] rxdPin,
  output wire [1:0] rmiiRxd,
  output wire rmiiRxdStrobe,
  input wire eqErrorRaw,
  output reg eqError,
  output reg eqCoef0Bypass,
  input wire [3:0] fastDropTriggers,
  input wire descramblerLockLoss,
  output reg fastLinkDown
);

  reg [15:0] controlTwo;
  reg [15:0] controlThree;
  reg [31:0] blinkCount;
  reg blinkPhase;
  reg nibbleOdd;
  reg stretchPending;
  reg [15:0] next_rdata;
  reg next_fullDuplex;
  wire extFullDuplex;
  wire enhancedLed;
  wire isolateEnable;
  wire idleErrEnable;
  wire oddNibbleDisable;
  wire [1:0] sampledRxd;
  wire sampledStrobe;
  wire linkIsFull100Tx;
  wire isolatedLink;
  wire descramblerDrop;
  wire lowTriggerDrop;
  wire [3:0] lowTriggerEnable;

  // Pick out the stored field at a given position
  function fieldBit;
    input [15:0] value;
    input integer pos;
    begin
      fieldBit = value[pos];
    end
  endfunction

  // Match a register address; the write decoder uses it for both registers
  function addrHit;
    input [4:0] addr;
    input [4:0] target;
    begin
      addrHit = (addr == target);
    end
  endfunction

  // Control two field taps
  assign extFullDuplex = fieldBit(controlTwo, `C2_EXT_FULL_DUPLEX);
  assign enhancedLed = fieldBit(controlTwo, `C2_ENHANCED_LED);
  assign isolateEnable = fieldBit(controlTwo, `C2_ISOLATE_MII);
  assign idleErrEnable = fieldBit(controlTwo, `C2_RXER_IDLE);
  assign oddNibbleDisable = fieldBit(controlTwo, `C2_ODD_NIBBLE_DIS);

  // Register writes; only documented fields are stored, others read zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      controlTwo <= `C2_RESET;
      controlThree <= `C3_RESET;
    end else if (regWrite) begin
      if (addrHit(regAddr, `ADDR_CONTROL_TWO)) begin
        controlTwo <= regWdata & `C2_MASK;
      end
      if (addrHit(regAddr, `ADDR_CONTROL_THREE)) begin
        controlThree <= regWdata & `C3_MASK;
      end
    end
  end

  // Read decode; an unmapped address answers zero
  always @* begin
    case (regAddr)
      `ADDR_CONTROL_TWO: next_rdata = controlTwo;
      `ADDR_CONTROL_THREE: next_rdata = controlThree;
      default: next_rdata = 16'h0000;
    endcase
  end

  // Read data stands for exactly the cycle after the strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 16'h0000;
    end else if (regRead) begin
      regRdata <= next_rdata;
    end else begin
      regRdata <= 16'h0000;
    end
  end

  // Duplex resolution; the extended mode overrides the standard outcome
  always @* begin
    if (!autoNegEnable) begin
      next_fullDuplex = forcedFullDuplex;
    end else if (partnerAutoNeg) begin
      next_fullDuplex = localFdAbility & partnerFdAbility;
    end else begin
      // Parallel detection cannot learn duplex, so the standard picks half
      next_fullDuplex = 1'b0;
    end
    if (extFullDuplex && partnerForced100Tx &&
        (autoNegEnable || forced100Tx)) begin
      next_fullDuplex = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resolvedFullDuplex <= 1'b0;
    end else begin
      resolvedFullDuplex <= next_fullDuplex;
    end
  end

  // Activity blink timer; long, so the period is a parameter
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blinkCount <= 32'h0;
      blinkPhase <= 1'b0;
    end else if (!linkActivity) begin
      blinkCount <= 32'h0;
      blinkPhase <= 1'b0;
    end else if (blinkCount >= BLINK_CYCLES - 1) begin
      blinkCount <= 32'h0;
      blinkPhase <= ~blinkPhase;
    end else begin
      blinkCount <= blinkCount + 32'h1;
    end
  end

  assign linkIsFull100Tx = linkUp & linkSpeed100 & ~linkFiber &
                           resolvedFullDuplex;

  // Link LED; enhanced mode trades activity indication for link quality
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linkLed <= 1'b0;
    end else if (enhancedLed) begin
      linkLed <= linkIsFull100Tx;
    end else begin
      linkLed <= linkUp & ~blinkPhase;
    end
  end

  // Links on which the isolate option acts: any 10 link or half duplex 100
  assign isolatedLink = linkUp & (~linkSpeed100 | ~resolvedFullDuplex);

  // MII isolation; active low isolate, so a high level enables the MII output drivers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      miiIsolate_n <= 1'b1;
    end else begin
      miiIsolate_n <= ~(isolateEnable & isolatedLink);
    end
  end

  // Receive error; idle symbol errors pass only when enabled
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxErOut <= 1'b0;
    end else begin
      rxErOut <= rxSymbolError & (~rxIdle | idleErrEnable);
    end
  end

  // Transmit path; nibble parity tracks frame length in nibbles
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nibbleOdd <= 1'b0;
      stretchPending <= 1'b0;
      txEnOut <= 1'b0;
      txErOut <= 1'b0;
    end else if (txEnIn) begin
      nibbleOdd <= ~nibbleOdd;
      stretchPending <= 1'b0;
      txEnOut <= 1'b1;
      txErOut <= txErIn;
    end else if (nibbleOdd && !oddNibbleDisable && !stretchPending) begin
      // Frame ended on an odd nibble: add one cycle carrying an error
      nibbleOdd <= 1'b0;
      stretchPending <= 1'b1;
      txEnOut <= 1'b1;
      txErOut <= 1'b1;
    end else begin
      nibbleOdd <= 1'b0;
      stretchPending <= 1'b0;
      txEnOut <= 1'b0;
      txErOut <= 1'b0;
    end
  end

  // RMII receive data capture against the selected reference
  rmii_rx_sampler rxSampler (
    .clk(clk),
    .rst_n(rst_n),
    .useRxClk(fieldBit(controlTwo, `C2_RMII_RXCLK_SEL)),
    .rxClkPin(rxClkPin),
    .crystalRefPin(crystal_reference_input),
    .rxdPin(rxdPin),
    .rxd(sampledRxd),
    .rxdStrobe(sampledStrobe)
  );

  // Isolated MII shows idle receive data rather than stale pairs
  assign rmiiRxd = miiIsolate_n ? sampledRxd : 2'h0;
  assign rmiiRxdStrobe = sampledStrobe & miiIsolate_n;

  // Equalizer error; bypass is on from reset, so raw errors start ignored
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eqError <= 1'b0;
    end else begin
      eqError <= eqErrorRaw &
                 ~fieldBit(controlThree, `C3_EQ_ERR_BYPASS);
    end
  end

  // Coefficient bypass; a registered copy of its control bit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eqCoef0Bypass <= 1'b0;
    end else begin
      eqCoef0Bypass <= fieldBit(controlThree, `C3_EQ_COEF_BYPASS);
    end
  end

  // Separate terms so no trigger has to wait on another to drop the link
  assign descramblerDrop = descramblerLockLoss &
                           fieldBit(controlThree, `C3_DESCR_FAST_DROP);
  assign lowTriggerEnable = controlThree[`C3_FAST_DROP_MSB:`C3_FAST_DROP_LSB];
  assign lowTriggerDrop = |(fastDropTriggers & lowTriggerEnable);

  // Fast link-down; every enabled trigger counts at once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fastLinkDown <= 1'b0;
    end else begin
      fastLinkDown <= descramblerDrop | lowTriggerDrop;
    end
  end

endmodule

// *** verilog/phy_link_option_defines.vh ***
// Offsets, field positions, reset values and timing for the link options
`ifndef PHY_LINK_OPTION_DEFINES_VH
`define PHY_LINK_OPTION_DEFINES_VH

// Register offsets on the management port
`define ADDR_CONTROL_TWO 5'h0a
`define ADDR_CONTROL_THREE 5'h0b

// Control two field positions
`define C2_EXT_FULL_DUPLEX 5
`define C2_ENHANCED_LED 4
`define C2_ISOLATE_MII 3
`define C2_RXER_IDLE 2
`define C2_ODD_NIBBLE_DIS 1
`define C2_RMII_RXCLK_SEL 0

// Control three field positions
`define C3_EQ_ERR_BYPASS 12
`define C3_DESCR_FAST_DROP 10
`define C3_EQ_COEF_BYPASS 9
`define C3_FAST_DROP_LSB 0
`define C3_FAST_DROP_MSB 3

// Stored field masks and reset values
`define C2_MASK 16'h003f
`define C3_MASK 16'h160f
`define C2_RESET 16'h0000
`define C3_RESET 16'h1000

// Activity blink half period and clock period
`define LED_BLINK_NS 50000000
`define CLK_PERIOD_NS 10
`define LED_BLINK_CYCLES (`LED_BLINK_NS / `CLK_PERIOD_NS)

`endif

// *** verilog/rmii_rx_sampler.v ***
// RMII receive data sampler with a selectable timing reference
`include "phy_link_option_defines.vh"

module rmii_rx_sampler (
  input wire clk,
  input wire rst_n,
  input wire useRxClk,
  input wire rxClkPin,
  input wire crystalRefPin,
  input wire [1:0] rxdPin,
  output reg [1:0] rxd,
  output reg rxdStrobe
);

  reg [1:0] rxClkSync;
  reg [1:0] refSync;
  reg [1:0] rxdMeta;
  reg [1:0] rxdStable;
  reg refLast;
  wire refNow;

  // Two flip-flops on every pin before any logic looks at it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxClkSync <= 2'h0;
      refSync <= 2'h0;
      rxdMeta <= 2'h0;
      rxdStable <= 2'h0;
    end else begin
      rxClkSync <= {rxClkSync[0], rxClkPin};
      refSync <= {refSync[0], crystalRefPin};
      rxdMeta <= rxdPin;
      rxdStable <= rxdMeta;
    end
  end

  // Selected reference; data and clocks see equal delay so they stay aligned
  assign refNow = useRxClk ? rxClkSync[1] : refSync[1];

  // Capture the data pair on each rising edge of the chosen reference
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refLast <= 1'b0;
      rxd <= 2'h0;
      rxdStrobe <= 1'b0;
    end else begin
      refLast <= refNow;
      rxdStrobe <= refNow & ~refLast;
      if (refNow && !refLast) begin
        rxd <= rxdStable;
      end
    end
  end

endmodule
